// File: hw/wfm_top.sv
// wfm_top: wake-up pattern 2 and 3 store and matcher with an axi4-lite slave
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wfm_top
  import wfm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // received frame bytes
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_last,
  // one-cycle match pulses, bit 0 pattern 2, bit 1 pattern 3
  output logic      [NPAT-1:0]   pattern_match
);

  // ==========================================================================
  // write channel state
  logic              aw_have_q;
  logic              aw_have_d;
  logic [IDX_W-1:0]  aw_idx_q;
  logic [IDX_W-1:0]  aw_idx_d;
  logic              w_have_q;
  logic              w_have_d;
  logic [REG_W-1:0]  w_data_q;
  logic [REG_W-1:0]  w_data_d;
  logic [1:0]        w_be_q;
  logic [1:0]        w_be_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;

  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic [NPAT-1:0]   wr_pat_hit;
  logic [SLOT_W-1:0] wr_slot;
  logic              wr_hit;

  // ==========================================================================
  // read channel state
  logic              rvalid_q;
  logic              rvalid_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;
  logic              ar_take;
  logic [IDX_W-1:0]  ar_idx;
  logic              rd_hit;
  logic [REG_W-1:0]  rd_word;
  logic [DATA_W-1:0] status_word;

  // ==========================================================================
  // frame tracking state
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              frame_end_q;
  logic              frame_end_d;
  logic [NPAT-1:0]   last_match_q;
  logic [NPAT-1:0]   last_match_d;
  logic              frame_busy;

  logic [REG_W-1:0]  words [NPAT][NWORD];
  logic [NPAT-1:0]   unit_match;

  wfm_byte_if rx_if ();

  // ==========================================================================
  // axi write: address and data taken in either order, answered together
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit        = |wr_pat_hit;

  always_comb begin
    wr_pat_hit = '0;
    wr_slot    = '0;
    for (int p = 0; p < NPAT; p++) begin
      for (int k = 0; k < NWORD; k++) begin
        if (aw_idx_q == REG_IDX[p][k]) begin
          wr_pat_hit[p] = 1'b1;
          wr_slot       = SLOT_W'(k);
        end
      end
    end
  end

  always_comb begin
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_be_d    = w_be_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (aw_take) begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[ADDR_W-1:2];
    end
    if (w_take) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata[REG_W-1:0];
      w_be_d   = s_axi_wstrb[1:0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= '0;
      w_be_q    <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_idx_q  <= aw_idx_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_be_q    <= w_be_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================================
  // pattern banks, one per pattern
  genvar gp;
  generate
    for (gp = 0; gp < NPAT; gp++) begin : g_pat
      wfm_pat_regs u_regs (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_pat_hit[gp]),
        .wr_slot (wr_slot),
        .wr_data (w_data_q),
        .wr_be   (w_be_q),
        .words   (words[gp])
      );

      wfm_crc_unit u_crc (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .rx       (rx_if.sink),
        .mask     ({words[gp][SLOT_MASK0+3], words[gp][SLOT_MASK0+2],
                    words[gp][SLOT_MASK0+1], words[gp][SLOT_MASK0]}),
        .expected ({words[gp][SLOT_CRC_HI], words[gp][SLOT_CRC_LO]}),
        .match    (unit_match[gp])
      );
    end
  endgenerate

  // ==========================================================================
  // axi read: one-cycle answer, unmapped gives slverr and zero
  assign s_axi_arready = !rvalid_q;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

  // ==========================================================================
  // read lookup, reserved gaps and odd indices miss
  always_comb begin
    rd_hit  = 1'b0;
    rd_word = REG_RESET;
    for (int p = 0; p < NPAT; p++) begin
      for (int k = 0; k < NWORD; k++) begin
        if (ar_idx == REG_IDX[p][k]) begin
          rd_hit  = 1'b1;
          rd_word = words[p][k];
        end
      end
    end
  end

  // ==========================================================================
  // status word: last frame results and frame in progress
  always_comb begin
    status_word                       = '0;
    status_word[ST_MATCH_LSB +: NPAT] = last_match_q;
    status_word[ST_BUSY_BIT]          = frame_busy;
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = RESP_SLVERR;
      if (rd_hit) begin
        rdata_d = {{(DATA_W-REG_W){1'b0}}, rd_word};
        rresp_d = RESP_OKAY;
      end else if (ar_idx == MATCH_STATUS_IDX) begin
        rdata_d = status_word;
        rresp_d = RESP_OKAY;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ==========================================================================
  // frame byte position, held at 64 past the masked window
  assign rx_if.vld    = rx_valid;
  assign rx_if.data   = rx_data;
  assign rx_if.last   = rx_last;
  assign rx_if.idx    = cnt_q;
  assign rx_if.in_win = (cnt_q < MATCH_BYTES);
  assign frame_busy   = (cnt_q != CNT_ZERO);

  always_comb begin
    cnt_d        = cnt_q;
    frame_end_d  = rx_valid && rx_last;
    last_match_d = frame_end_q ? unit_match : last_match_q;
    if (rx_valid) begin
      if (rx_last) cnt_d = CNT_ZERO;
      else if (cnt_q < MATCH_BYTES) cnt_d = cnt_q + CNT_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q        <= CNT_ZERO;
      frame_end_q  <= 1'b0;
      last_match_q <= '0;
    end else begin
      cnt_q        <= cnt_d;
      frame_end_q  <= frame_end_d;
      last_match_q <= last_match_d;
    end
  end

  assign pattern_match = unit_match;

endmodule : wfm_top
`default_nettype wire

// File: include/wfm_pkg.sv
// wfm_pkg: constants, register map and crc helper for the wake-up pattern matcher
`default_nettype none
package wfm_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam int REG_W  = 16;
  localparam int DATA_W = 32;
  localparam int NPAT   = 2;
  localparam int NWORD  = 6;
  localparam int SLOT_W = 3;
  localparam int MASK_W = 64;
  localparam int CNT_W  = 7;
  localparam int CRC_W  = 32;

  // ==========================================================================
  // register indices, byte address is index times four
  localparam logic [IDX_W-1:0] PATTERN2_CRC_LOW_IDX    = 10'h150;
  localparam logic [IDX_W-1:0] PATTERN2_CRC_HIGH_IDX   = 10'h152;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_WORD0_IDX = 10'h154;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_WORD1_IDX = 10'h156;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_WORD2_IDX = 10'h158;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_WORD3_IDX = 10'h15A;
  localparam logic [IDX_W-1:0] PATTERN3_CRC_LOW_IDX    = 10'h160;
  localparam logic [IDX_W-1:0] PATTERN3_CRC_HIGH_IDX   = 10'h162;
  localparam logic [IDX_W-1:0] PATTERN3_MASK_WORD0_IDX = 10'h164;
  localparam logic [IDX_W-1:0] PATTERN3_MASK_WORD1_IDX = 10'h166;
  localparam logic [IDX_W-1:0] PATTERN3_MASK_WORD2_IDX = 10'h168;
  localparam logic [IDX_W-1:0] PATTERN3_MASK_WORD3_IDX = 10'h16A;
  localparam logic [IDX_W-1:0] MATCH_STATUS_IDX        = 10'h100;

  localparam logic [IDX_W-1:0] REG_IDX [NPAT][NWORD] = '{
    '{PATTERN2_CRC_LOW_IDX, PATTERN2_CRC_HIGH_IDX, PATTERN2_MASK_WORD0_IDX,
      PATTERN2_MASK_WORD1_IDX, PATTERN2_MASK_WORD2_IDX, PATTERN2_MASK_WORD3_IDX},
    '{PATTERN3_CRC_LOW_IDX, PATTERN3_CRC_HIGH_IDX, PATTERN3_MASK_WORD0_IDX,
      PATTERN3_MASK_WORD1_IDX, PATTERN3_MASK_WORD2_IDX, PATTERN3_MASK_WORD3_IDX}
  };

  // word slots inside one pattern bank
  localparam int SLOT_CRC_LO = 0;
  localparam int SLOT_CRC_HI = 1;
  localparam int SLOT_MASK0  = 2;

  // ==========================================================================
  // reset values, status fields, bus answers
  localparam logic [REG_W-1:0] REG_RESET   = 16'h0000;
  localparam logic [CRC_W-1:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [CRC_W-1:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [CNT_W-1:0] MATCH_BYTES = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 7'h01;
  localparam int ST_MATCH_LSB = 0;
  localparam int ST_BUSY_BIT  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // reflected ethernet crc step over one byte, lsb first
  function automatic logic [CRC_W-1:0] crc_byte(input logic [CRC_W-1:0] c,
                                                input logic [7:0] b);
    logic [CRC_W-1:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

endpackage : wfm_pkg
`default_nettype wire

// File: include/wfm_byte_if.sv
// wfm_byte_if: received frame byte stream from the top to the crc units
`timescale 1ns/1ps
`default_nettype none
interface wfm_byte_if;
  import wfm_pkg::*;
  logic             vld;
  logic [7:0]       data;
  logic             last;
  logic [CNT_W-1:0] idx;
  logic             in_win;
  modport src  (output vld, data, last, idx, in_win);
  modport sink (input  vld, data, last, idx, in_win);
endinterface : wfm_byte_if
`default_nettype wire

// File: hw/wfm_pat_regs.sv
// wfm_pat_regs: the six 16-bit words of one wake-up pattern
`timescale 1ns/1ps
`default_nettype none
module wfm_pat_regs
  import wfm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              wr_en,
  input  wire logic [SLOT_W-1:0] wr_slot,
  input  wire logic [REG_W-1:0]  wr_data,
  input  wire logic [1:0]        wr_be,
  output logic      [REG_W-1:0]  words [NWORD]
);

  logic [REG_W-1:0] words_q [NWORD];
  logic [REG_W-1:0] words_d [NWORD];

  always_comb begin
    for (int k = 0; k < NWORD; k++) begin
      words_d[k] = words_q[k];
      if (wr_en && (wr_slot == SLOT_W'(k))) begin
        if (wr_be[0]) words_d[k][7:0]  = wr_data[7:0];
        if (wr_be[1]) words_d[k][15:8] = wr_data[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int k = 0; k < NWORD; k++) begin
      if (!aresetn) words_q[k] <= REG_RESET;
      else          words_q[k] <= words_d[k];
    end
  end

  assign words = words_q;

endmodule : wfm_pat_regs
`default_nettype wire

// File: hw/wfm_crc_unit.sv
// wfm_crc_unit: masked crc over the first bytes of a frame for one pattern
`timescale 1ns/1ps
`default_nettype none
module wfm_crc_unit
  import wfm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  wfm_byte_if.sink               rx,
  input  wire logic [MASK_W-1:0] mask,
  input  wire logic [CRC_W-1:0]  expected,
  output logic                   match
);

  logic [CRC_W-1:0] crc_q;
  logic [CRC_W-1:0] crc_d;
  logic             match_q;
  logic             match_d;

  always_comb begin
    logic [CRC_W-1:0] c;
    c       = crc_q;
    crc_d   = crc_q;
    match_d = 1'b0;
    if (rx.vld) begin
      // mask bit n picks frame byte n+1; beyond byte 64 nothing enters
      if (rx.in_win && mask[rx.idx[5:0]]) c = crc_byte(crc_q, rx.data);
      crc_d = rx.last ? CRC_INIT : c;
      // an empty mask never matches
      if (rx.last) match_d = (|mask) && ((~c) == expected);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_q   <= CRC_INIT;
      match_q <= 1'b0;
    end else begin
      crc_q   <= crc_d;
      match_q <= match_d;
    end
  end

  assign match = match_q;

endmodule : wfm_crc_unit
`default_nettype wire

// File: tb/wfm_monitor.sv
// wfm_monitor: bus and match timing checks on the pattern block ports
`timescale 1ns/1ps
`default_nettype none
module wfm_monitor
  import wfm_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              rx_valid,
  input wire logic              rx_last,
  input wire logic [NPAT-1:0]   pattern_match
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // read and write steps
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence aw_w_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence rsvd_ar;
    ar_take ##0 (s_axi_araddr[11:2] inside {[10'h15C:10'h15F], [10'h16C:10'h16F]});
  endsequence
  sequence pat_ar;
    ar_take ##0 (s_axi_araddr[11:2] inside {[10'h150:10'h15A], [10'h160:10'h16A]})
      ##0 !s_axi_araddr[2];
  endsequence
  // ==========================================================================
  // assertions
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_rsvd_slverr: assert property (rsvd_ar |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == 32'h00000000) else $error("reserved read not refused");
  a_pat_okay: assert property (pat_ar |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
    && s_axi_rdata[31:16] == 16'h0000) else $error("pattern read bad");
  a_bvalid_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rvalid_refuses: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_match_cause: assert property (pattern_match != 2'b00 |->
    $past(rx_valid && rx_last) || $past(rx_valid && rx_last, 2))
    else $error("match without frame end");
  a_reset_quiet: assert property ($rose(aresetn) |-> pattern_match == 2'b00
    && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not cleared by reset");
endmodule : wfm_monitor
bind wfm_top wfm_monitor wfm_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .rx_valid, .rx_last, .pattern_match);
`default_nettype wire

// File: tb/wfm_rx_model.sv
// wfm_rx_model: receive path handing frame bytes to the matcher
`timescale 1ns/1ps
`default_nettype none
module wfm_rx_model (
  input  wire logic       aclk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_last  = 1'b0;
  end
  function automatic logic [7:0] fb(input int i, input logic [7:0] s);
    return 8'(i * 37) ^ s;
  endfunction : fb
  // idle cycles show inverted data so stale bytes cannot pass
  task automatic send(input int n, input logic [7:0] s, input int gap);
    for (int i = 1; i <= n; i++) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data  <= fb(i, s);
      rx_last  <= (i == n);
      if (i < n) repeat (gap) begin
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_data  <= ~fb(i, s);
      end
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    rx_last  <= 1'b0;
  endtask : send
endmodule : wfm_rx_model
`default_nettype wire

// File: tb/wfm_tb_top.sv
// wfm_tb_top: register and frame match tests for the wake-up pattern block
`timescale 1ns/1ps
`default_nettype none
module wfm_tb_top
  import wfm_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_valid, rx_last;
  logic [7:0] rx_data;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, pattern_match, r;
  logic [15:0] v;
  logic [63:0] m;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  wfm_top wfm_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid,
    .rx_data, .rx_last, .pattern_match);
  wfm_rx_model wfm_rx_model_i (.aclk, .rx_valid, .rx_data, .rx_last);
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end
  // ==========================================================================
  // tasks
  task automatic final_report();
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] dv, input logic [3:0] st);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, dv};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  function automatic logic [31:0] ecrc(input logic [63:0] mk, input int n, input logic [7:0] s);
    logic [31:0] c;
    logic [7:0] b;
    c = 32'hFFFFFFFF;
    for (int i = 1; i <= n && i <= 64; i++) begin
      b = wfm_rx_model_i.fb(i, s);
      if (mk[i-1]) for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction : ecrc
  task automatic pg(input int p, input logic [63:0] mk, input logic [31:0] c);
    logic [15:0] w [NWORD];
    w = '{c[15:0], c[31:16], mk[15:0], mk[31:16], mk[47:32], mk[63:48]};
    for (int i = 0; i < NWORD; i++) begin
      wr({REG_IDX[p][i], 2'b00}, w[i], 4'h3);
      chk("write resp", 32'(r), 32'(RESP_OKAY));
    end
  endtask : pg
  task automatic frm(input int n, input logic [7:0] s, input int gap, input logic [1:0] ex);
    logic [1:0] got;
    got = 2'b00;
    wfm_rx_model_i.send(n, s, gap);
    repeat (4) begin
      @(posedge aclk);
      got = got | pattern_match;
    end
    chk("pattern_match", 32'(got), 32'(ex));
    rd({MATCH_STATUS_IDX, 2'b00});
    chk("status", 32'(d[2:0]), 32'({1'b0, ex}));
  endtask : frm
  // ==========================================================================
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NPAT * NWORD; i++) begin
      rd({REG_IDX[i/NWORD][i%NWORD], 2'b00});
      chk("reset value", d, 32'h00000000);
    end
    for (int i = 0; i < NPAT * NWORD; i++) wr({REG_IDX[i/NWORD][i%NWORD], 2'b00}, 16'(i * 16'h0B0D), 4'h3);
    for (int i = 0; i < NPAT * NWORD; i++) begin
      rd({REG_IDX[i/NWORD][i%NWORD], 2'b00});
      chk("readback", d, 32'(16'(i * 16'h0B0D)));
    end
    v = 16'(6 * 16'h0B0D);
    wr({PATTERN3_CRC_LOW_IDX, 2'b00}, 16'h0000, 4'h1);
    rd({PATTERN3_CRC_LOW_IDX, 2'b00});
    chk("strobe write", d, {16'h0000, v[15:8], 8'h00});
    wr({PATTERN3_CRC_LOW_IDX, 2'b00}, 16'hFFFF, 4'h2);
    rd({PATTERN3_CRC_LOW_IDX, 2'b00});
    chk("upper strobe", d, 32'h0000FF00);
    rd(12'h570);
    chk("reserved read", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(12'h5B0, 16'hFFFF, 4'h3);
    chk("reserved write", 32'(r), 32'(RESP_SLVERR));
    rd({PATTERN3_MASK_WORD3_IDX, 2'b00});
    chk("gap write leak", d, 32'(16'(11 * 16'h0B0D)));
    for (int k = 0; k < 4; k++) begin
      m = (64'h1 << (16 * k)) | (64'h1 << (16 * k + 15));
      pg(0, m, ecrc(m, 80, 8'h11));
      pg(1, '1, ecrc('1, 80, 8'h22));
      frm(80, 8'h11, k, 2'b01);
    end
    frm(70, 8'h22, 0, 2'b10);
    final_report();
  end
endmodule : wfm_tb_top
`default_nettype wire
